// [uas_pkg.sv]
// shared constants and types for the usb address/status register block
// assumes a 20 MHz system clock and an 8-bit register port
package uas_pkg;

	// register offsets
	localparam logic [7:0] UAS_ADDR_WAKE_OFF   = 8'h42;
	localparam logic [7:0] UAS_CTRL_STATUS_OFF = 8'h20;

	// address_wake_reg fields
	localparam int UAS_WAKE_EN_BIT = 0;
	localparam int UAS_ADDR_LSB    = 1;
	localparam int UAS_ADDR_MSB    = 7;

	// usb_ctrl_status_reg fields
	localparam int UAS_SUSPENDED_FLAG_BIT     = 0;
	localparam int UAS_WAKE_CMD_BIT = 1;
	localparam int UAS_RESET_BIT    = 2;
	localparam int UAS_RESUME_BIT   = 3;
	localparam int UAS_DIN_BIT      = 4;
	localparam int UAS_CIN_BIT      = 5;
	localparam int UAS_DOUT_BIT     = 6;
	localparam int UAS_COUT_BIT     = 7;

	// values after reset
	localparam logic [7:0] UAS_ADDR_WAKE_RST = 8'h00;
	localparam logic       UAS_PS2_OUT_RST   = 1'b1;

	// timing
	localparam int UAS_CLK_KHZ       = 20000;
	localparam int UAS_IDLE_MS       = 3;
	localparam int UAS_RESUME_MS     = 20;
	localparam int UAS_WAKE_DRIVE_MS = 10;
	localparam int UAS_WAKE_MIN_US   = 2;
	localparam int UAS_BUS_RESET_NS  = 2500;
	localparam int UAS_IDLE_CYC      = UAS_IDLE_MS * UAS_CLK_KHZ;
	localparam int UAS_RESUME_CYC    = UAS_RESUME_MS * UAS_CLK_KHZ;
	localparam int UAS_WAKE_DRV_CYC  = UAS_WAKE_DRIVE_MS * UAS_CLK_KHZ;
	localparam int UAS_WAKE_MIN_CYC  =
		(UAS_WAKE_MIN_US * UAS_CLK_KHZ + 999) / 1000;
	localparam int UAS_BUS_RST_CYC   =
		(UAS_BUS_RESET_NS * UAS_CLK_KHZ + 999999) / 1000000;
	localparam int UAS_CNT_W         = 20;

	// register port request
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic       we;
		logic       re;
	} uas_bus_req_t;

	// one two-way pin as seen from the driving side
	typedef struct packed {
		logic out;
		logic oe_n;
	} uas_pin_t;

	// link state of the interface engine
	typedef enum logic [2:0] {
		LS_ACTIVE  = 3'b001,
		LS_SUSPEND = 3'b010,
		LS_RESUME  = 3'b100
	} uas_link_t;

endpackage

// [uas_regs.sv]
// usb address/wake register, control/status register and link watcher
// assumes firmware on the register port and a usb or ps/2 host on the pins
`timescale 1ns/1ps
`default_nettype none

module uas_regs
	import uas_pkg::*;
#(
	parameter int unsigned IDLE_CYC   = UAS_IDLE_CYC,
	parameter int unsigned RESUME_CYC = UAS_RESUME_CYC,
	parameter int unsigned WAKE_CYC   = UAS_WAKE_DRV_CYC
) (
	input  wire logic         clk,
	input  wire logic         rst_n,
	input  wire uas_bus_req_t bus_req,
	output logic [7:0]        rdata,
	input  wire logic         usb_mode,
	input  wire logic         usb_clock_on,
	input  wire logic         secondary_suspend_ctl,
	input  wire logic         minus_line_in,
	input  wire logic         plus_line_in,
	output uas_pin_t          minus_line_pin,
	output uas_pin_t          plus_line_pin,
	output logic              usb_irq,
	output logic [6:0]        device_address,
	output logic              remote_wake_enable
);

	localparam logic [UAS_CNT_W-1:0] IDLE_LIM   = UAS_CNT_W'(IDLE_CYC - 1);
	localparam logic [UAS_CNT_W-1:0] RESUME_LIM = UAS_CNT_W'(RESUME_CYC - 1);
	localparam logic [UAS_CNT_W-1:0] WAKE_LIM   = UAS_CNT_W'(WAKE_CYC - 1);
	localparam logic [7:0] WMIN_LIM = 8'(UAS_WAKE_MIN_CYC);
	localparam logic [7:0] RST_LIM  = 8'(UAS_BUS_RST_CYC);

	// pin synchronisers
	logic [1:0] dm_sync_q;
	logic [1:0] dp_sync_q;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			dm_sync_q <= 2'h0;
			dp_sync_q <= 2'h0;
		end else begin
			dm_sync_q <= {dm_sync_q[0], minus_line_in};
			dp_sync_q <= {dp_sync_q[0], plus_line_in};
		end
	end
	wire logic dm = dm_sync_q[1];
	wire logic dp = dp_sync_q[1];

	// low-speed line states: idle is J
	wire logic bus_j   = dm & ~dp;
	wire logic bus_k   = ~dm & dp;
	wire logic bus_se0 = ~dm & ~dp;
	wire logic detect_on = usb_mode & usb_clock_on & ~secondary_suspend_ctl;

	// register decode
	function automatic logic hit(input uas_bus_req_t r, input logic [7:0] a);
		hit = (r.addr == a);
	endfunction
	wire logic wr_aw = bus_req.we & hit(bus_req, UAS_ADDR_WAKE_OFF);
	wire logic wr_cs = bus_req.we & hit(bus_req, UAS_CTRL_STATUS_OFF);
	wire logic rd_cs = bus_req.re & hit(bus_req, UAS_CTRL_STATUS_OFF);

	// state
	uas_link_t             link_q, link_d;
	logic [UAS_CNT_W-1:0]  idle_cnt_q, idle_cnt_d;
	logic [UAS_CNT_W-1:0]  res_cnt_q, res_cnt_d;
	logic [UAS_CNT_W-1:0]  wake_cnt_q, wake_cnt_d;
	logic [7:0]            se0_cnt_q, se0_cnt_d;
	logic [7:0]            hi_cnt_q, hi_cnt_d;
	logic                  wake_cmd_q;
	logic                  wake_drive_q, wake_drive_d;
	logic                  bus_reset_q, bus_reset_d;
	logic                  ps2_data_out_q;
	logic                  ps2_clk_out_q;
	logic [6:0]            addr_q;
	logic                  wake_en_q;

	wire logic suspended_flag_q = (link_q != LS_ACTIVE);
	wire logic suspended_flag_d = (link_d != LS_ACTIVE);
	wire logic resume_q = (link_q == LS_RESUME);
	wire logic resume_d = (link_d == LS_RESUME);
	wire logic reset_hit = (se0_cnt_q == RST_LIM - 8'h01) & bus_se0 & usb_mode;

	// idle timer, counts only while detection is enabled
	assign idle_cnt_d = (!detect_on || !bus_j || link_q != LS_ACTIVE) ?
		'0 : (idle_cnt_q == IDLE_LIM ? idle_cnt_q : idle_cnt_q + 1'b1);
	// se0 length for bus reset
	assign se0_cnt_d = (!bus_se0 || !usb_mode) ? 8'h00 :
		(se0_cnt_q == RST_LIM ? se0_cnt_q : se0_cnt_q + 8'h01);
	// resume visibility timer
	assign res_cnt_d = (link_q != LS_RESUME) ? '0 :
		(res_cnt_q == RESUME_LIM ? res_cnt_q : res_cnt_q + 1'b1);

	always_comb begin
		link_d = link_q;
		unique case (link_q)
			LS_ACTIVE: begin
				if (detect_on && bus_j && idle_cnt_q == IDLE_LIM)
					link_d = LS_SUSPEND;
			end
			LS_SUSPEND: begin
				if (reset_hit)
					link_d = LS_ACTIVE;
				else if (usb_mode && bus_k)
					link_d = LS_RESUME;
			end
			LS_RESUME: begin
				if (reset_hit || (res_cnt_q == RESUME_LIM && !bus_k))
					link_d = LS_ACTIVE;
			end
		endcase
	end

	// bus reset flag: set by reset, cleared by engine on suspend entry
	assign bus_reset_d = reset_hit ? 1'b1 :
		((link_d == LS_SUSPEND && link_q == LS_ACTIVE) ? 1'b0 :
		bus_reset_q);

	// wake command: high time measured, accepted on its clearing write
	wire logic cmd_wr_val = bus_req.wdata[UAS_WAKE_CMD_BIT];
	assign hi_cnt_d = !wake_cmd_q ? 8'h00 :
		(hi_cnt_q == WMIN_LIM ? hi_cnt_q : hi_cnt_q + 8'h01);
	wire logic wake_accept = wr_cs & ~cmd_wr_val & wake_cmd_q &
		(hi_cnt_q == WMIN_LIM) & wake_en_q & suspended_flag_q & usb_mode;
	assign wake_cnt_d = !wake_drive_q ? '0 : wake_cnt_q + 1'b1;
	assign wake_drive_d = wake_accept ? 1'b1 :
		((wake_drive_q && wake_cnt_q == WAKE_LIM) ? 1'b0 :
		wake_drive_q);

	// interrupt on suspend edges, resume and bus reset
	wire logic irq_d = (suspended_flag_d != suspended_flag_q) |
		(resume_d & ~resume_q) | reset_hit;

	// pin drive: usb mode drives K during wake, ps/2 mode is open drain
	wire uas_pin_t dm_pin_d = usb_mode ?
		uas_pin_t'{out: 1'b0, oe_n: ~wake_drive_q} :
		uas_pin_t'{out: 1'b0, oe_n: ps2_data_out_q};
	wire uas_pin_t dp_pin_d = usb_mode ?
		uas_pin_t'{out: 1'b1, oe_n: ~wake_drive_q} :
		uas_pin_t'{out: 1'b0, oe_n: ps2_clk_out_q};

	// read data; write-only fields read as zero
	wire logic [7:0] cs_word = {2'b00,
		dp & ps2_clk_out_q,
		dm & ps2_data_out_q,
		resume_q, bus_reset_q, 1'b0, suspended_flag_q};
	wire logic [7:0] rd_d = rd_cs ? cs_word : 8'h00;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			link_q       <= LS_ACTIVE;
			idle_cnt_q   <= '0;
			res_cnt_q    <= '0;
			wake_cnt_q   <= '0;
			se0_cnt_q    <= 8'h00;
			hi_cnt_q     <= 8'h00;
			wake_drive_q <= 1'b0;
			bus_reset_q  <= 1'b0;
			usb_irq      <= 1'b0;
			rdata        <= 8'h00;
		end else begin
			link_q       <= link_d;
			idle_cnt_q   <= idle_cnt_d;
			res_cnt_q    <= res_cnt_d;
			wake_cnt_q   <= wake_cnt_d;
			se0_cnt_q    <= se0_cnt_d;
			hi_cnt_q     <= hi_cnt_d;
			wake_drive_q <= wake_drive_d;
			bus_reset_q  <= bus_reset_d;
			usb_irq      <= irq_d;
			rdata        <= rd_d;
		end
	end

	// firmware-written fields
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			addr_q    <= UAS_ADDR_WAKE_RST[UAS_ADDR_MSB:UAS_ADDR_LSB];
			wake_en_q <= UAS_ADDR_WAKE_RST[UAS_WAKE_EN_BIT];
		end else if (wr_aw) begin
			addr_q    <= bus_req.wdata[UAS_ADDR_MSB:UAS_ADDR_LSB];
			wake_en_q <= bus_req.wdata[UAS_WAKE_EN_BIT];
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wake_cmd_q     <= 1'b0;
			ps2_data_out_q <= UAS_PS2_OUT_RST;
			ps2_clk_out_q  <= UAS_PS2_OUT_RST;
		end else if (wr_cs) begin
			wake_cmd_q     <= cmd_wr_val;
			ps2_data_out_q <= bus_req.wdata[UAS_DOUT_BIT];
			ps2_clk_out_q  <= bus_req.wdata[UAS_COUT_BIT];
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			minus_line_pin     <= '{out: 1'b0, oe_n: 1'b1};
			plus_line_pin      <= '{out: 1'b0, oe_n: 1'b1};
			device_address     <= 7'h00;
			remote_wake_enable <= 1'b0;
		end else begin
			minus_line_pin     <= dm_pin_d;
			plus_line_pin      <= dp_pin_d;
			device_address     <= addr_q;
			remote_wake_enable <= wake_en_q;
		end
	end

	// checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	a_addr_write: assert property (
		wr_aw |-> ##2 device_address == $past(bus_req.wdata[7:1], 2))
		else $error("address field not loaded from write");

	a_addr_reads_zero: assert property (
		bus_req.re && bus_req.addr == UAS_ADDR_WAKE_OFF |=> rdata == 8'h00)
		else $error("write-only register read nonzero");

	a_suspended_flag_edge_irq: assert property (
		$changed(suspended_flag_q) |-> usb_irq)
		else $error("suspend change without interrupt");

	a_idle_suspend: assert property (
		link_q == LS_ACTIVE && detect_on && bus_j && idle_cnt_q == IDLE_LIM
		|=> suspended_flag_q && usb_irq)
		else $error("idle bus did not enter suspend");

	a_reset_flag_irq: assert property (
		$rose(bus_reset_q) |-> usb_irq)
		else $error("bus reset without interrupt");

	a_resume_clears: assert property (
		$fell(suspended_flag_q) |-> !resume_q)
		else $error("resume still set after suspend fell");

	a_resume_irq: assert property (
		$rose(resume_q) |-> usb_irq && suspended_flag_q)
		else $error("resume set without interrupt");

	a_resume_hold: assert property (
		$fell(resume_q) && !$past(reset_hit) |-> $past(res_cnt_q) == RESUME_LIM)
		else $error("resume dropped before its hold time");

	a_ps2_masked_read: assert property (
		rd_cs && !ps2_data_out_q |=> rdata[UAS_DIN_BIT] == 1'b0)
		else $error("ps2 data input read while output low");

	a_ps2_data_drive: assert property (
		!usb_mode && !ps2_data_out_q |=> minus_line_pin.oe_n == 1'b0)
		else $error("ps2 data pin not pulled low");

	a_wake_drive_k: assert property (
		wake_accept |=> ##1 !plus_line_pin.oe_n && plus_line_pin.out
		&& !minus_line_pin.oe_n)
		else $error("accepted wake command did not drive K");

	a_ps2_clk_drive: assert property (
		!usb_mode && !ps2_clk_out_q |=> plus_line_pin.oe_n == 1'b0)
		else $error("ps2 clock pin not pulled low");

	a_ps2_release: assert property (
		!usb_mode && ps2_data_out_q && ps2_clk_out_q
		|=> minus_line_pin.oe_n && plus_line_pin.oe_n)
		else $error("ps2 pins driven while released");

	a_reset_flag_set: assert property (
		reset_hit |=> bus_reset_q)
		else $error("bus reset not recorded");

	a_cmd_reads_zero: assert property (
		rd_cs |=> rdata[UAS_WAKE_CMD_BIT] == 1'b0 && rdata[7:6] == 2'h0)
		else $error("write-only status bits read nonzero");

	a_detect_gate: assert property (
		link_q == LS_ACTIVE && !detect_on |=> !suspended_flag_q)
		else $error("suspend entered with detection off");

endmodule

`default_nettype wire

// [uas_host_model.sv]
// host on the two bus pins: usb line states or ps/2 open-drain pull-ups
// assumes the resolved levels feed the block's pin inputs
`timescale 1ns/1ps
`default_nettype none
module uas_host_model
	import uas_pkg::*;
(
	input  wire uas_pin_t   minus_line_pin,
	input  wire uas_pin_t   plus_line_pin,
	input  wire logic       usb_mode,
	input  wire logic [1:0] host_drive,
	output logic            minus_line_in,
	output logic            plus_line_in
);
	// usb: 0 idle j, 1 k, 2 se0; ps/2: bit0 pulls data, bit1 pulls clock
	wire logic host_dm = (host_drive == 2'h0);
	wire logic host_dp = (host_drive == 2'h1);
	wire logic ps2_dm  = !host_drive[0] && minus_line_pin.oe_n;
	wire logic ps2_dp  = !host_drive[1] && plus_line_pin.oe_n;
	assign minus_line_in = !usb_mode ? ps2_dm :
		(minus_line_pin.oe_n ? host_dm : minus_line_pin.out);
	assign plus_line_in = !usb_mode ? ps2_dp :
		(plus_line_pin.oe_n ? host_dp : plus_line_pin.out);
endmodule
`default_nettype wire

// [usb_address_status_regs_bench.sv]
// self-checking bench for the usb address/status register block
// assumes the host model on the pins and a 20 MHz clock
`timescale 1ns/1ps
`default_nettype none
module usb_address_status_regs_bench
	import uas_pkg::*;
;
	localparam int IDLE_T = 200;
	localparam int RES_T  = 300;
	localparam int WAKE_T = 100;
	logic         clk = 1'b0;
	logic         rst_n = 1'b0;
	uas_bus_req_t bus_req = '0;
	logic [7:0]   rdata;
	logic         usb_mode = 1'b0;
	logic         usb_clock_on = 1'b1;
	logic         secondary_suspend_ctl = 1'b0;
	logic         minus_line_in;
	logic         plus_line_in;
	uas_pin_t     minus_line_pin;
	uas_pin_t     plus_line_pin;
	logic         usb_irq;
	logic [6:0]   device_address;
	logic         remote_wake_enable;
	logic [1:0]   host_drive = 2'h0;
	logic [7:0]   rd_v;
	int           error_cnt = 0;
	int           samples_checked = 0;
	int           irq_cnt = 0;
	int           irq0;

	always #25 clk = ~clk;
	always @(posedge clk) if (usb_irq === 1'b1) irq_cnt <= irq_cnt + 1;

	uas_regs #(.IDLE_CYC(IDLE_T), .RESUME_CYC(RES_T), .WAKE_CYC(WAKE_T))
	uas_regs_inst (.clk(clk), .rst_n(rst_n), .bus_req(bus_req),
		.rdata(rdata), .usb_mode(usb_mode), .usb_clock_on(usb_clock_on),
		.secondary_suspend_ctl(secondary_suspend_ctl),
		.minus_line_in(minus_line_in), .plus_line_in(plus_line_in),
		.minus_line_pin(minus_line_pin), .plus_line_pin(plus_line_pin),
		.usb_irq(usb_irq), .device_address(device_address),
		.remote_wake_enable(remote_wake_enable));

	uas_host_model uas_host_model_inst (.minus_line_pin(minus_line_pin),
		.plus_line_pin(plus_line_pin), .usb_mode(usb_mode),
		.host_drive(host_drive), .minus_line_in(minus_line_in),
		.plus_line_in(plus_line_in));

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			error_cnt++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic final_report();
		$display("errors %0d checks %0d", error_cnt, samples_checked);
		if (error_cnt == 0 && samples_checked > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		bus_req <= '{addr: a, wdata: d, we: 1'b1, re: 1'b0};
		@(posedge clk);
		bus_req.we <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a);
		@(posedge clk);
		bus_req <= '{addr: a, wdata: 8'h00, we: 1'b0, re: 1'b1};
		@(posedge clk);
		bus_req.re <= 1'b0;
		#1 rd_v = rdata;
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask

	// ps/2 pins: released lines, driven data line, host holding clock
	task automatic t_ps2();
		rd(UAS_CTRL_STATUS_OFF);
		chk(rd_v, 8'h30);
		wr(UAS_CTRL_STATUS_OFF, 8'h8D);
		cyc(2);
		chk(8'({minus_line_pin.oe_n, plus_line_pin.oe_n}), 8'h01);
		rd(UAS_CTRL_STATUS_OFF);
		chk(rd_v, 8'h20);
		host_drive <= 2'h2;
		cyc(3);
		rd(UAS_CTRL_STATUS_OFF);
		chk(rd_v, 8'h00);
		host_drive <= 2'h0;
		wr(UAS_CTRL_STATUS_OFF, 8'h40);
		cyc(2);
		chk(8'({minus_line_pin.oe_n, plus_line_pin.oe_n}), 8'h02);
		rd(UAS_CTRL_STATUS_OFF);
		chk(rd_v, 8'h10);
		wr(UAS_CTRL_STATUS_OFF, 8'hC0);
	endtask

	// address register write, write-only readback, unmapped address
	task automatic t_addr();
		chk(8'({device_address, remote_wake_enable}), UAS_ADDR_WAKE_RST);
		wr(UAS_ADDR_WAKE_OFF, 8'h0B);
		cyc(2);
		chk(8'(device_address), 8'h05);
		chk(8'(remote_wake_enable), 8'h01);
		rd(UAS_ADDR_WAKE_OFF);
		chk(rd_v, 8'h00);
		rd(8'h55);
		chk(rd_v, 8'h00);
	endtask

	// usb bus reset, idle with detection off, then idle into suspend
	task automatic t_rst_suspended_flag();
		usb_mode <= 1'b1;
		secondary_suspend_ctl <= 1'b1;
		irq0 = irq_cnt;
		host_drive <= 2'h2;
		cyc(60);
		host_drive <= 2'h0;
		cyc(5);
		chk(8'(irq_cnt - irq0), 8'h01);
		rd(UAS_CTRL_STATUS_OFF);
		chk(rd_v & 8'h04, 8'h04);
		irq0 = irq_cnt;
		cyc(IDLE_T + 30);
		rd(UAS_CTRL_STATUS_OFF);
		chk(rd_v & 8'h01, 8'h00);
		cyc(1);
		secondary_suspend_ctl <= 1'b0;
		cyc(IDLE_T + 30);
		rd(UAS_CTRL_STATUS_OFF);
		chk(rd_v & 8'h0F, 8'h01);
		chk(8'(irq_cnt - irq0), 8'h01);
	endtask

	// remote wake pulse, host resume, return to active
	task automatic t_wake();
		int n;
		wr(UAS_CTRL_STATUS_OFF, 8'hC2);
		cyc(45);
		wr(UAS_CTRL_STATUS_OFF, 8'hC0);
		n = 0;
		while (minus_line_pin.oe_n !== 1'b0) begin
			if (n++ > 8) begin
				error_cnt++;
				final_report();
			end
			@(posedge clk);
		end
		#1 chk(8'({minus_line_pin, plus_line_pin}), 8'h02);
		cyc(WAKE_T + 10);
		host_drive <= 2'h1;
		cyc(30);
		rd(UAS_CTRL_STATUS_OFF);
		chk(rd_v & 8'h09, 8'h09);
		irq0 = irq_cnt;
		host_drive <= 2'h0;
		cyc(RES_T);
		rd(UAS_CTRL_STATUS_OFF);
		chk(rd_v & 8'h09, 8'h00);
		chk(8'(irq_cnt != irq0), 8'h01);
	endtask

	initial begin
		cyc(16);
		rst_n <= 1'b1;
		t_addr();
		t_ps2();
		t_rst_suspended_flag();
		t_wake();
		final_report();
	end
endmodule
`default_nettype wire
